// ### rtl/pld_defines.vh
// register offsets, field positions, reset values and sizes of the macrocell fabric
`ifndef PLD_DEFINES_VH
`define PLD_DEFINES_VH

// ------------------------------------------------------------
// fabric sizes
// ------------------------------------------------------------
`define PLD_NUM_INPUTS 10
`define PLD_NUM_PIN_CELLS 10
`define PLD_NUM_BURIED_CELLS 8
`define PLD_NUM_CELLS 18
`define PLD_NUM_SUM_TERMS 36
`define PLD_RESET_TERM_INDEX 64
`define PLD_OE_TERM_FIRST 65
`define PLD_OE_TERM_LAST 74
`define PLD_ARCH_WORD_BITS 68

// ------------------------------------------------------------
// register byte offsets (apb, one aligned word each)
// ------------------------------------------------------------
`define PLD_ADDR_W 8
`define PLD_OFS_INPUT_CTRL 8'h00
`define PLD_OFS_CLOCK_SOURCE 8'h04
`define PLD_OFS_BYPASS 8'h08
`define PLD_OFS_DATA_POL 8'h0C
`define PLD_OFS_ENABLE_POL 8'h10
`define PLD_OFS_CELL_STATE 8'h14
`define PLD_OFS_INPUT_STATE 8'h18

// ------------------------------------------------------------
// input control field positions
// ------------------------------------------------------------
`define PLD_BIT_INPUT_SYNC 0
`define PLD_BIT_INPUT_LATCH 1
`define PLD_BIT_BIDIR_SYNC 2
`define PLD_BIT_BIDIR_LATCH 3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define PLD_RST_INPUT_CTRL 4'h0
`define PLD_RST_CELL_CFG 18'h00000
`define PLD_RST_DATA_POL 10'h000

`endif

// ### rtl/pld_input_group.v
// one input cell group: asynchronous, latched or registered capture of synced pins
`default_nettype none

module pld_input_group (
    input wire i_clock,          // system clock
    input wire i_rst,            // async reset, active high
    input wire [9:0] i_pin,      // synced pin levels
    input wire i_cap_level,      // synced input capture clock level
    input wire i_cap_rise,       // one-cycle pulse on capture clock rise
    input wire i_sync_select,    // 1: latch or register path
    input wire i_latch_select,   // 1: latch, 0: register
    output wire [9:0] o_value    // value seen by the array
);

    reg [9:0] hold_reg;

    genvar b;
    generate
        for (b = 0; b < 10; b = b + 1) begin : g_bit
            always @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    hold_reg[b] <= 1'b0;
                end else if (i_latch_select) begin
                    // transparent while the capture clock is high
                    if (i_cap_level) begin
                        hold_reg[b] <= i_pin[b];
                    end
                end else if (i_cap_rise) begin
                    hold_reg[b] <= i_pin[b];
                end
            end
            // latch mode is shown live while open, as a real latch would be
            assign o_value[b] = !i_sync_select ? i_pin[b] :
                (i_latch_select && i_cap_level) ? i_pin[b] : hold_reg[b];
        end
    endgenerate

endmodule

`default_nettype wire

// ### rtl/pld_state_cell.v
// one output or buried state cell: combinational, sum-term clocked or clock-enabled register
`default_nettype none

module pld_state_cell (
    input wire i_clock,          // system clock
    input wire i_clear,          // async clear, active high
    input wire i_data_term,      // data sum term
    input wire i_enable_term,    // enable or clock sum term
    input wire i_enable_pol,     // enable term polarity select
    input wire i_clock_source,   // 1: common output clock
    input wire i_bypass,         // 1: combinational
    input wire i_ock_rise,       // pulse on output register clock rise
    output wire o_value          // cell value before the pin buffer
);

    reg q_reg;
    reg e_prev_reg;
    wire e_eff;

    assign e_eff = i_enable_term ^ i_enable_pol;

    always @(posedge i_clock or posedge i_clear) begin
        if (i_clear) begin
            q_reg <= 1'b0;
            e_prev_reg <= 1'b1; // a term left high across a clear is no edge
        end else begin
            e_prev_reg <= e_eff;
            if (!i_bypass) begin
                if (i_clock_source) begin
                    if (i_ock_rise && e_eff) begin
                        q_reg <= i_data_term;
                    end
                    // inactive enable keeps the state
                end else if (e_eff && !e_prev_reg) begin
                    q_reg <= i_data_term;
                end
            end
        end
    end

    // bypass set with clock source set is not a valid setting; treated as combinational
    assign o_value = i_bypass ? i_data_term : q_reg;

endmodule

`default_nettype wire

// ### rtl/pld_fabric.v
// macrocell fabric: input groups, output and buried cells, apb architecture registers
//
// Contract
// - each input group: async, latched or registered
// - latch transparent while capture clock high
// - register captures on capture clock rise
// - sync bit picks capture path, latch bit type
// - latch when latch bit set, else register
// - eight buried cells feed array only
// - ten output cells drive pins and feed back
// - output and buried cells configured one by one
// - common clock with enable term as enable
// - enable term clocks register directly
// - bypass makes cell combinational
// - output cell pin polarity selectable
// - buried cells have no polarity bit
// - enable term polarity selectable per cell
// - output pins bidirectional, own enable term
// - reset term clears all cell registers asynchronously
// - registers reset low, pins show high
// - output cells feed back before and after buffer
// - term 64 resets, terms 65-74 enable outputs
// - 18 data and 18 enable sum terms
// - power-up clears all registers low
//
// Design decisions made here: the register addresses and register access over APB.
`include "pld_defines.vh"
`default_nettype none

module pld_fabric (
    input wire i_clock,                  // 50 MHz system clock
    input wire i_rst,                    // async reset, active high
    input wire i_psel,                   // apb select
    input wire i_penable,                // apb enable
    input wire i_pwrite,                 // apb direction
    input wire [7:0] i_paddr,            // apb byte address
    input wire [31:0] i_pwdata,          // apb write data
    output wire [31:0] o_prdata,         // apb read data
    output wire o_pready,                // apb ready
    output wire o_pslverr,               // apb error on unmapped address
    input wire [9:0] i_dedicated_pin,    // dedicated input pins
    input wire [9:0] i_bidir_pin,        // bidirectional pin levels
    output wire [9:0] o_bidir_pin,       // bidirectional pin drive level
    output wire [9:0] o_bidir_oe,        // bidirectional pin drive enable
    input wire i_input_capture_clock,    // input capture clock pin
    input wire i_output_register_clock,  // output register clock pin
    input wire [17:0] i_data_sum_term,   // data sum terms, one per cell
    input wire [17:0] i_enable_sum_term, // enable or clock sum terms
    input wire i_reset_product_term,     // common cell reset term
    input wire [9:0] i_output_enable_term, // output enable product terms
    output wire [9:0] o_dedicated_feedback, // dedicated input cells to array
    output wire [9:0] o_bidir_feedback,  // bidir input cells to array
    output wire [17:0] o_cell_feedback,  // cell values before the buffer
    output wire o_capture_clock_feedback // capture clock level to array
);

    // ------------------------------------------------------------
    // architecture registers
    // ------------------------------------------------------------
    reg [3:0] input_ctrl_reg;
    reg [17:0] clock_source_reg;
    reg [17:0] bypass_reg;
    reg [9:0] data_pol_reg;
    reg [17:0] enable_pol_reg;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    reg [31:0] prdata_reg;
    reg pready_reg;
    reg pslverr_reg;
    reg [31:0] rdata_next;
    reg hit_next;
    wire apb_setup;
    wire apb_write;

    assign apb_setup = i_psel && !i_penable;
    assign apb_write = i_psel && i_penable && pready_reg && i_pwrite;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    reg [9:0] ded_meta_reg;
    reg [9:0] ded_sync_reg;
    reg [9:0] bid_meta_reg;
    reg [9:0] bid_sync_reg;
    reg [1:0] clk_meta_reg;
    reg [1:0] clk_sync_reg;
    reg [1:0] clk_prev_reg;
    wire icap_rise;
    wire ock_rise;

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            ded_meta_reg <= 10'h000;
            ded_sync_reg <= 10'h000;
            bid_meta_reg <= 10'h000;
            bid_sync_reg <= 10'h000;
            clk_meta_reg <= 2'h0;
            clk_sync_reg <= 2'h0;
            clk_prev_reg <= 2'h0;
        end else begin
            ded_meta_reg <= i_dedicated_pin;
            ded_sync_reg <= ded_meta_reg;
            bid_meta_reg <= i_bidir_pin;
            bid_sync_reg <= bid_meta_reg;
            clk_meta_reg <= {i_output_register_clock, i_input_capture_clock};
            clk_sync_reg <= clk_meta_reg;
            clk_prev_reg <= clk_sync_reg;
        end
    end

    assign icap_rise = clk_sync_reg[0] && !clk_prev_reg[0];
    assign ock_rise = clk_sync_reg[1] && !clk_prev_reg[1];

    // ------------------------------------------------------------
    // input cell groups, each configured as a whole
    // ------------------------------------------------------------
    wire [9:0] ded_value;
    wire [9:0] bid_value;

    pld_input_group u_dedicated_input_cell (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pin(ded_sync_reg),
        .i_cap_level(clk_sync_reg[0]),
        .i_cap_rise(icap_rise),
        .i_sync_select(input_ctrl_reg[`PLD_BIT_INPUT_SYNC]),
        .i_latch_select(input_ctrl_reg[`PLD_BIT_INPUT_LATCH]),
        .o_value(ded_value)
    );

    // the bidir pin reads back the driven level while enabled, else the outside data
    pld_input_group u_bidir_pin_input_cell (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_pin(bid_sync_reg),
        .i_cap_level(clk_sync_reg[0]),
        .i_cap_rise(icap_rise),
        .i_sync_select(input_ctrl_reg[`PLD_BIT_BIDIR_SYNC]),
        .i_latch_select(input_ctrl_reg[`PLD_BIT_BIDIR_LATCH]),
        .o_value(bid_value)
    );

    // ------------------------------------------------------------
    // output and buried state cells
    // ------------------------------------------------------------
    // cells 0..9 are pin output cells, 10..17 buried state cells
    wire cell_clear;
    wire [17:0] cell_value;

    // a glitch on the reset term clears the cells; keep that term clean in the array
    assign cell_clear = i_rst || i_reset_product_term;

    genvar c;
    generate
        for (c = 0; c < `PLD_NUM_CELLS; c = c + 1) begin : g_cell
            pld_state_cell u_cell (
                .i_clock(i_clock),
                .i_clear(cell_clear),
                .i_data_term(i_data_sum_term[c]),
                .i_enable_term(i_enable_sum_term[c]),
                .i_enable_pol(enable_pol_reg[c]),
                .i_clock_source(clock_source_reg[c]),
                .i_bypass(bypass_reg[c]),
                .i_ock_rise(ock_rise),
                .o_value(cell_value[c])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // pin buffers and feedback
    // ------------------------------------------------------------
    reg [9:0] pin_out_reg;
    reg [9:0] pin_oe_reg;
    reg [9:0] ded_fb_reg;
    reg [9:0] bid_fb_reg;
    reg [17:0] cell_fb_reg;
    reg capclk_fb_reg;

    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pin_out_reg <= 10'h3FF;
            pin_oe_reg <= 10'h000;
            ded_fb_reg <= 10'h000;
            bid_fb_reg <= 10'h000;
            cell_fb_reg <= 18'h00000;
            capclk_fb_reg <= 1'b0;
        end else begin
            // inverting buffer; the polarity bit undoes the inversion
            pin_out_reg <= ~(cell_value[9:0] ^ data_pol_reg);
            pin_oe_reg <= i_output_enable_term;
            ded_fb_reg <= ded_value;
            bid_fb_reg <= bid_value;
            // buried cells reach only this feedback, never a pin
            cell_fb_reg <= cell_value;
            capclk_fb_reg <= clk_sync_reg[0];
        end
    end

    assign o_bidir_pin = pin_out_reg;
    assign o_bidir_oe = pin_oe_reg;
    assign o_dedicated_feedback = ded_fb_reg;
    assign o_bidir_feedback = bid_fb_reg;
    assign o_cell_feedback = cell_fb_reg;
    assign o_capture_clock_feedback = capclk_fb_reg;

    // ------------------------------------------------------------
    // register read decode
    // ------------------------------------------------------------
    always @* begin
        rdata_next = 32'h00000000;
        hit_next = 1'b1;
        case (i_paddr)
            `PLD_OFS_INPUT_CTRL: begin
                rdata_next[3:0] = input_ctrl_reg;
            end
            `PLD_OFS_CLOCK_SOURCE: begin
                rdata_next[17:0] = clock_source_reg;
            end
            `PLD_OFS_BYPASS: begin
                rdata_next[17:0] = bypass_reg;
            end
            `PLD_OFS_DATA_POL: begin
                rdata_next[9:0] = data_pol_reg;
            end
            `PLD_OFS_ENABLE_POL: begin
                rdata_next[17:0] = enable_pol_reg;
            end
            `PLD_OFS_CELL_STATE: begin
                rdata_next[17:0] = cell_fb_reg;
            end
            `PLD_OFS_INPUT_STATE: begin
                rdata_next[19:0] = {bid_fb_reg, ded_fb_reg};
            end
            default: begin
                hit_next = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // apb handshake: one wait-free access phase
    // ------------------------------------------------------------
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg <= apb_setup;
            if (apb_setup) begin
                prdata_reg <= i_pwrite ? 32'h00000000 : rdata_next;
                pslverr_reg <= !hit_next;
            end else begin
                pslverr_reg <= 1'b0;
            end
        end
    end

    assign o_prdata = prdata_reg;
    assign o_pready = pready_reg;
    assign o_pslverr = pslverr_reg;

    // ------------------------------------------------------------
    // architecture register writes
    // ------------------------------------------------------------
    // a write takes effect at the access edge; cells switch mode at once, so
    // change modes only while the pins feeding the array are quiet
    always @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            input_ctrl_reg <= `PLD_RST_INPUT_CTRL;
            clock_source_reg <= `PLD_RST_CELL_CFG;
            bypass_reg <= `PLD_RST_CELL_CFG;
            data_pol_reg <= `PLD_RST_DATA_POL;
            enable_pol_reg <= `PLD_RST_CELL_CFG;
        end else if (apb_write) begin
            case (i_paddr)
                `PLD_OFS_INPUT_CTRL: begin
                    input_ctrl_reg <= i_pwdata[3:0];
                end
                `PLD_OFS_CLOCK_SOURCE: begin
                    clock_source_reg <= i_pwdata[17:0];
                end
                `PLD_OFS_BYPASS: begin
                    bypass_reg <= i_pwdata[17:0];
                end
                `PLD_OFS_DATA_POL: begin
                    data_pol_reg <= i_pwdata[9:0];
                end
                `PLD_OFS_ENABLE_POL: begin
                    enable_pol_reg <= i_pwdata[17:0];
                end
                default: begin
                    input_ctrl_reg <= input_ctrl_reg;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ### verif/pld_fabric_properties.sv
// port assertions for the macrocell fabric
`default_nettype none
module pld_fabric_properties (
    input wire logic i_clock,                    // clock
    input wire logic i_rst,                      // async reset
    input wire logic i_psel,                     // apb select
    input wire logic i_penable,                  // apb enable
    input wire logic [7:0] i_paddr,              // apb address
    input wire logic [31:0] o_prdata,            // read data
    input wire logic o_pready,                   // ready
    input wire logic o_pslverr,                  // error
    input wire logic [9:0] o_bidir_pin,          // pin level
    input wire logic [9:0] o_bidir_oe,           // pin enable
    input wire logic [9:0] i_output_enable_term, // enable terms
    input wire logic [17:0] o_cell_feedback,     // cell values
    input wire logic i_input_capture_clock,      // capture clock pin
    input wire logic o_capture_clock_feedback    // synced capture clock
);
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // helper
    // ------------------------------------------------------------
    // $past looks back at most three edges, so wait that long after reset
    logic [1:0] since_rst;
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            since_rst <= 2'h0;
        end else if (since_rst != 2'h3) begin
            since_rst <= since_rst + 2'h1;
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_aligned_setup;
        s_setup ##0 (i_paddr[1:0] == 2'h0);
    endsequence
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    property p_ready;
        s_setup |=> o_pready;
    endproperty
    property p_ready_pulse;
        o_pready |=> !o_pready;
    endproperty
    property p_err_decode;
        s_aligned_setup |=> o_pslverr == ($past(i_paddr) > 8'h18);
    endproperty
    property p_err_ready;
        o_pslverr |-> o_pready && o_prdata == 32'h0;
    endproperty
    property p_prdata_hold;
        !(i_psel && !i_penable) |=> $stable(o_prdata);
    endproperty
    property p_oe_follow;
        since_rst != 2'h0 |-> o_bidir_oe == $past(i_output_enable_term);
    endproperty
    property p_reset_state;
        disable iff (1'b0) i_rst |-> o_bidir_pin == 10'h3FF && o_bidir_oe == 10'h000
            && o_cell_feedback == 18'h00000 && !o_pready;
    endproperty
    property p_capture_sync;
        since_rst == 2'h3 |-> o_capture_clock_feedback == $past(i_input_capture_clock, 3);
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_err_decode: assert property (p_err_decode) else $error("error flag wrong for address");
    a_err_ready: assert property (p_err_ready) else $error("error without ready or with data");
    a_prdata_hold: assert property (p_prdata_hold) else $error("read data moved");
    a_oe_follow: assert property (p_oe_follow) else $error("enable not from term");
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");
    a_capture_sync: assert property (p_capture_sync) else $error("capture clock feedback late");
endmodule
`default_nettype wire

// ### verif/board_model.sv
// board side: drives input pins and both clock pins, resolves the bidirectional pins
`default_nettype none
module board_model (
    input wire logic i_clock,       // clock
    input wire logic [9:0] i_drive, // device drive level
    input wire logic [9:0] i_oe,    // device drive enable
    output logic [9:0] o_pin,       // resolved pin level
    output logic [9:0] o_ded,       // dedicated pins
    output logic o_icap,            // input capture clock
    output logic o_ock              // output register clock
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] val = 10'h000;
    logic [9:0] en = 10'h000;
    logic [9:0] last = 10'h000;
    initial begin
        o_ded = 10'h000;
        o_icap = 1'b0;
        o_ock = 1'b0;
    end
    // no pull-ups: a floating pin shows a level that flips every cycle
    always_comb begin
        for (int k = 0; k < 10; k++) begin
            o_pin[k] = i_oe[k] ? i_drive[k] : (en[k] ? val[k] : ~last[k]);
        end
    end
    always @(posedge i_clock) begin
        last <= o_pin;
    end
    task set_pins(input logic [9:0] d, input logic [9:0] v, input logic [9:0] e);
        @(posedge i_clock);
        o_ded <= d;
        val <= v;
        en <= e;
    endtask
    task set_icap(input logic lvl);
        @(posedge i_clock);
        o_icap <= lvl;
    endtask
    // clock pins stay high and low long enough to pass the pin synchronisers
    task pulse(input logic which);
        @(posedge i_clock);
        if (which) o_ock <= 1'b1;
        else o_icap <= 1'b1;
        repeat (4) @(posedge i_clock);
        o_ock <= 1'b0;
        o_icap <= 1'b0;
        repeat (4) @(posedge i_clock);
    endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench of the macrocell fabric with the board model on its pins
`include "pld_defines.vh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [17:0] pat_a = 18'h2A5C3;
    localparam logic [17:0] pat_b = 18'h15A3C;
    localparam logic [17:0] pat_c = 18'h3C00F;
    localparam logic [17:0] ce_mask = 18'h0FF00;
    logic i_clock, i_rst, psel, penable, pwrite, pready, pslverr, er, icap, ock, rst_t, icap_fb;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] ded, bin, bout, boe, oe_t, ded_fb, bid_fb;
    logic [17:0] d_t, e_t, cell_fb;
    int error_cnt = 0;
    int samples_checked = 0;
    typedef struct {logic [7:0] a; logic [31:0] m; logic e;} row_t;
    row_t rows[6];
    pld_fabric dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_dedicated_pin(ded), .i_bidir_pin(bin),
        .o_bidir_pin(bout), .o_bidir_oe(boe), .i_input_capture_clock(icap),
        .i_output_register_clock(ock), .i_data_sum_term(d_t), .i_enable_sum_term(e_t),
        .i_reset_product_term(rst_t), .i_output_enable_term(oe_t),
        .o_dedicated_feedback(ded_fb), .o_bidir_feedback(bid_fb), .o_cell_feedback(cell_fb),
        .o_capture_clock_feedback(icap_fb));
    board_model board_u (.i_clock(i_clock), .i_drive(bout), .i_oe(boe), .o_pin(bin),
        .o_ded(ded), .o_icap(icap), .o_ock(ock));
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task test_done;
        $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clock);
        penable <= 1'b1;
        do begin
            @(posedge i_clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic exp_e);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
        check(er, exp_e);
    endtask
    task terms(input logic [17:0] d, input logic [17:0] e, input logic r, input logic [9:0] o);
        @(posedge i_clock);
        d_t <= d;
        e_t <= e;
        rst_t <= r;
        oe_t <= o;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge i_clock);
        @(negedge i_clock);
    endtask
    function automatic logic [9:0] pin_of(input logic [17:0] d, input logic [9:0] pol);
        return ~(d[9:0] ^ pol);
    endfunction
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        rows = '{'{`PLD_OFS_INPUT_CTRL, 32'h0000000F, 1'b0},
            '{`PLD_OFS_CLOCK_SOURCE, 32'h0003FFFF, 1'b0}, '{`PLD_OFS_BYPASS, 32'h0003FFFF, 1'b0},
            '{`PLD_OFS_DATA_POL, 32'h000003FF, 1'b0}, '{`PLD_OFS_ENABLE_POL, 32'h0003FFFF, 1'b0},
            '{8'h1C, 32'h00000000, 1'b1}};
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {d_t, e_t, rst_t, oe_t} = '0;
        i_rst <= 1'b1;
        repeat (3) @(posedge i_clock);
        i_rst <= 1'b0;
        cyc(0);
        check(bout, 10'h3FF);
        check(cell_fb, 18'h0);
        for (int k = 0; k < 6; k++) begin
            rdchk(rows[k].a, 32'h0, rows[k].e);
            apb(1'b1, rows[k].a, 32'hFFFFFFFF);
            rdchk(rows[k].a, rows[k].m, rows[k].e);
            apb(1'b1, rows[k].a, 32'h0);
        end
        apb(1'b1, `PLD_OFS_BYPASS, 32'h3FFFF);
        apb(1'b1, `PLD_OFS_DATA_POL, 32'h2AA);
        terms(pat_a, 18'h0, 1'b0, 10'h3FF);
        cyc(5);
        check(cell_fb, pat_a);
        check(bout, pin_of(pat_a, 10'h2AA));
        check(bid_fb, pin_of(pat_a, 10'h2AA));
        apb(1'b1, `PLD_OFS_CELL_STATE, 32'hFFFFFFFF);
        rdchk(`PLD_OFS_CELL_STATE, pat_a, 1'b0);
        board_u.set_pins(10'h0F0, 10'h155, 10'h3FF);
        terms(pat_a, 18'h0, 1'b0, 10'h0);
        cyc(5);
        check(bid_fb, 10'h155);
        check(ded_fb, 10'h0F0);
        apb(1'b1, `PLD_OFS_BYPASS, 32'h0);
        apb(1'b1, `PLD_OFS_DATA_POL, 32'h0);
        terms(pat_a, 18'h3FFFF, 1'b0, 10'h0);
        cyc(2);
        check(cell_fb, pat_a);
        terms(pat_b, 18'h3FFFF, 1'b0, 10'h0);
        apb(1'b1, `PLD_OFS_ENABLE_POL, 32'h3FFFF);
        cyc(2);
        check(cell_fb, pat_a);
        terms(pat_c, 18'h0, 1'b0, 10'h0);
        cyc(2);
        check(cell_fb, pat_c);
        terms(pat_c, 18'h0, 1'b1, 10'h0);
        cyc(1);
        check(cell_fb, 18'h0);
        check(bout, 10'h3FF);
        terms(pat_c, 18'h0, 1'b0, 10'h0);
        apb(1'b1, `PLD_OFS_ENABLE_POL, 32'h0);
        apb(1'b1, `PLD_OFS_CLOCK_SOURCE, 32'h3FFFF);
        terms(pat_a, 18'h3FFFF, 1'b0, 10'h0);
        cyc(2);
        check(cell_fb, 18'h0);
        board_u.pulse(1'b1);
        check(cell_fb, pat_a);
        terms(pat_b, ce_mask, 1'b0, 10'h0);
        board_u.pulse(1'b1);
        check(cell_fb, (pat_b & ce_mask) | (pat_a & ~ce_mask));
        apb(1'b1, `PLD_OFS_INPUT_CTRL, 32'h5);
        board_u.set_pins(10'h3C3, 10'h0AA, 10'h3FF);
        cyc(4);
        check(ded_fb, 10'h0);
        board_u.pulse(1'b0);
        check(ded_fb, 10'h3C3);
        check(bid_fb, 10'h0AA);
        apb(1'b1, `PLD_OFS_INPUT_CTRL, 32'hF);
        board_u.set_icap(1'b1);
        board_u.set_pins(10'h155, 10'h2AA, 10'h3FF);
        cyc(5);
        check(ded_fb, 10'h155);
        board_u.set_icap(1'b0);
        cyc(4);
        board_u.set_pins(10'h0F0, 10'h30F, 10'h3FF);
        cyc(5);
        check(ded_fb, 10'h155);
        check(bid_fb, 10'h2AA);
        @(posedge i_clock);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clock);
        i_rst <= 1'b0;
        cyc(0);
        check(cell_fb, 18'h0);
        rdchk(`PLD_OFS_CLOCK_SOURCE, 32'h0, 1'b0);
        test_done;
    end
    initial begin
        repeat (5000) @(posedge i_clock);
        error_cnt++;
        test_done;
    end
endmodule
bind pld_fabric pld_fabric_properties chk_u (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel),
    .i_penable(i_penable), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_bidir_pin(o_bidir_pin), .o_bidir_oe(o_bidir_oe),
    .i_output_enable_term(i_output_enable_term), .o_cell_feedback(o_cell_feedback),
    .i_input_capture_clock(i_input_capture_clock),
    .o_capture_clock_feedback(o_capture_clock_feedback));
`default_nettype wire
